// File: inc/qdu_pkg.sv
// Summary of operation
// - mode 00, no power-down: data goes to the picked channel's staging register only.
// - mode 01: data goes to the picked staging register and its output register.
// - mode 10: picked staging register written, all four outputs loaded together.
// - power-down flag set: high byte bits 7..6 are the power-down code, data bits zero.
// - mode 11, pick-high clear: every output loads from its own staging register.
// - mode 11, pick-high set, no power-down: all four channels take the data.
// - mode 11, pick-high set, power-down: all four channels take the code.
// - high data byte is the upper eight bits of the 12-bit word.
// - low data byte upper nibble is the lower four bits; lower nibble ignored.
// - updates follow the falling edge of the clock acknowledging the low byte, once synchronised to the core clock.
// - staging and output registers clear to zero at reset.
// - rising edge on the load pin copies all staging registers to outputs, unless a word update lands in the same core cycle; that edge is lost.
// - last command byte is held in an 8-bit register read out on command_byte; decoding uses xferCmd_r.
// - staging registers are 14 bits: code on top, twelve data bits below.
// - output registers are 14 bits with same split; loads change the output.
// - the device answers as a write-only receiver at a 7-bit address.
// - modes 00 to 10 update only when command bits 7..6 match the extended address pins.
// - address recognised as 10011, two address-pin bits, then the write bit.
// - with power-down flag set, exactly two data bytes are accepted.
package qdu_pkg;
    localparam int   DATA_W      = 12;
    localparam int   REG_W       = 14;
    localparam int   NUM_CH      = 4;
    localparam int   CH_W        = 2;
    // command byte fields
    localparam int   CMD_EXT_HI  = 7;
    localparam int   CMD_EXT_LO  = 6;
    localparam int   CMD_MODE_HI = 5;
    localparam int   CMD_MODE_LO = 4;
    localparam int   CMD_PICK_HI = 2;
    localparam int   CMD_PICK_LO = 1;
    localparam int   CMD_PD      = 0;
    // update modes
    localparam logic [1:0] MODE_STAGE = 2'h0;
    localparam logic [1:0] MODE_LOAD  = 2'h1;
    localparam logic [1:0] MODE_ALL   = 2'h2;
    localparam logic [1:0] MODE_BCAST = 2'h3;
    // bus address
    localparam logic [4:0] ADDR_FIXED = 5'h13;
    localparam logic [7:0] ADDR_BCAST = 8'h90;
    // byte phases within a frame
    localparam logic [2:0] PH_ADDR = 3'h0;
    localparam logic [2:0] PH_CMD  = 3'h1;
    localparam logic [2:0] PH_HIGH = 3'h2;
    localparam logic [2:0] PH_LOW  = 3'h3;
    localparam logic [2:0] PH_DONE = 3'h4;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    localparam logic [REG_W-1:0] REG_RST = 14'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;
endpackage

// File: logic/qdu_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser, output moves once stages two and three agree
module qdu_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // ==================================================
    // capture chain
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q    <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q <= s3_r;
            end
        end
    end
endmodule

// File: logic/qdu_top.sv
`timescale 1ns/1ps
// quad converter command decode and register update
module qdu_top
    import qdu_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             sclClk,
    input  wire logic             frameStart,
    input  wire logic             sdaIn,
    output logic                  sdaOut,
    output logic                  sdaOeN,
    input  wire logic             addr_pin_hi,
    input  wire logic             addr_pin_lo,
    input  wire logic             ext_addr_bit_hi,
    input  wire logic             ext_addr_bit_lo,
    input  wire logic             async_load_pin,
    output logic [REG_W-1:0]      output_channel_a,
    output logic [REG_W-1:0]      output_channel_b,
    output logic [REG_W-1:0]      output_channel_c,
    output logic [REG_W-1:0]      output_channel_d,
    output logic [REG_W-1:0]      staging_channel_a,
    output logic [REG_W-1:0]      staging_channel_b,
    output logic [REG_W-1:0]      staging_channel_c,
    output logic [REG_W-1:0]      staging_channel_d,
    output logic [7:0]            command_byte
);
    // ==================================================
    // link domain: byte receiver on the bus clock
    logic [3:0] bitCnt_r;
    logic [2:0] phase_r;
    logic [6:0] shift_r;
    logic       selected_r;
    logic       ackPend_r;
    logic       wordFire_r;
    logic       wordTgl_r;
    logic [7:0] linkCmd_r;
    logic [7:0] linkHigh_r;
    logic [7:0] xferCmd_r;
    logic [7:0] xferHigh_r;
    logic [7:0] xferLow_r;
    logic [1:0] addrStrap_r;
    logic       strapTaken_r;
    logic [7:0] rxByte;
    logic       addrMatch;

    assign rxByte    = {shift_r, sdaIn};
    // address check against strap pins, write only, or broadcast
    assign addrMatch = (rxByte[7:1] == {ADDR_FIXED, addrStrap_r} && !rxByte[0]) || rxByte == ADDR_BCAST;

    // bit counter and phase tracking
    always_ff @(posedge sclClk) begin
        if (frameStart) begin
            bitCnt_r <= 4'h0;
            phase_r  <= PH_ADDR;
        end else if (bitCnt_r == BIT_ACK) begin
            bitCnt_r <= 4'h0;
            if (phase_r == PH_LOW) begin
                phase_r <= linkCmd_r[CMD_PD] ? PH_DONE : PH_HIGH;
            end else if (phase_r != PH_DONE) begin
                phase_r <= phase_r + 3'h1;
            end
        end else begin
            bitCnt_r <= bitCnt_r + 4'h1;
            shift_r  <= rxByte[6:0];
        end
    end

    // byte handling and acknowledge decision
    always_ff @(posedge sclClk) begin
        if (frameStart) begin
            selected_r <= 1'b0;
            ackPend_r  <= 1'b0;
            wordFire_r <= 1'b0;
        end else if (bitCnt_r == BIT_LAST) begin
            wordFire_r <= 1'b0;
            unique case (phase_r)
                PH_ADDR: begin
                    selected_r <= addrMatch;
                    ackPend_r  <= addrMatch;
                end
                PH_CMD: begin
                    linkCmd_r <= rxByte;
                    ackPend_r <= selected_r;
                end
                PH_HIGH: begin
                    linkHigh_r <= rxByte;
                    ackPend_r  <= selected_r;
                end
                PH_LOW: begin
                    xferCmd_r  <= linkCmd_r;
                    xferHigh_r <= linkHigh_r;
                    xferLow_r  <= rxByte;
                    ackPend_r  <= selected_r;
                end
                PH_DONE: begin
                    ackPend_r <= 1'b0;
                end
                default: begin
                    ackPend_r <= 1'b0;
                end
            endcase
        end else if (bitCnt_r == BIT_ACK) begin
            ackPend_r  <= 1'b0;
            wordFire_r <= ackPend_r && phase_r == PH_LOW;
        end else begin
            wordFire_r <= 1'b0;
        end
    end

    // ack drive and word hand-off on the falling edge
    always_ff @(negedge sclClk) begin
        if (frameStart) begin
            sdaOeN <= 1'b1;
        end else begin
            sdaOeN <= ~ackPend_r;
        end
    end

    // word released at the ack falling edge
    // core reset clears the toggle while the bus clock stands still
    always_ff @(negedge sclClk or posedge reset) begin
        if (reset) begin
            wordTgl_r <= 1'b0;
        end else if (wordFire_r) begin
            wordTgl_r <= ~wordTgl_r;
        end
    end

    assign sdaOut = 1'b0;

    // ==================================================
    // core domain: crossings
    logic wordSeen;
    logic wordSeenPrev_r;
    logic loadLvl;
    logic loadPrev_r;
    logic [1:0] extAddr;
    logic wordEvt;
    logic loadEvt;

    qdu_sync3 #(.WIDTH(1)) u_word_sync (
        .clk   (clk),
        .reset (reset),
        .d     (wordTgl_r),
        .q     (wordSeen)
    );
    qdu_sync3 #(.WIDTH(1)) u_load_sync (
        .clk   (clk),
        .reset (reset),
        .d     (async_load_pin),
        .q     (loadLvl)
    );
    qdu_sync3 #(.WIDTH(2)) u_ext_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({ext_addr_bit_hi, ext_addr_bit_lo}),
        .q     (extAddr)
    );

    // edge memories
    always_ff @(posedge clk) begin
        if (reset) begin
            wordSeenPrev_r <= 1'b0;
            loadPrev_r     <= 1'b0;
        end else begin
            wordSeenPrev_r <= wordSeen;
            loadPrev_r     <= loadLvl;
        end
    end

    assign wordEvt = wordSeen != wordSeenPrev_r;
    assign loadEvt = loadLvl && !loadPrev_r;

    // address straps taken once after reset release
    always_ff @(posedge clk) begin
        if (reset) begin
            strapTaken_r <= 1'b0;
        end else if (!strapTaken_r) begin
            strapTaken_r <= 1'b1;
            addrStrap_r  <= {addr_pin_hi, addr_pin_lo};
        end
    end

    // ==================================================
    // command decode
    logic [1:0]       mode;
    logic [CH_W-1:0]  pick;
    logic             pdFlag;
    logic             extOk;
    logic [REG_W-1:0] newWord;

    assign mode   = xferCmd_r[CMD_MODE_HI:CMD_MODE_LO];
    assign pick   = xferCmd_r[CMD_PICK_HI:CMD_PICK_LO];
    assign pdFlag = xferCmd_r[CMD_PD];
    assign extOk  = xferCmd_r[CMD_EXT_HI:CMD_EXT_LO] == extAddr;
    assign newWord = pdFlag ? {xferHigh_r[7:6], DATA_ZERO} : {2'b00, xferHigh_r, xferLow_r[7:4]};

    // ==================================================
    // staging and output registers
    logic [REG_W-1:0] stage_r [NUM_CH];
    logic [REG_W-1:0] outp_r  [NUM_CH];
    logic [7:0]       cmd_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_r <= 8'h00;
        end else if (wordEvt) begin
            cmd_r <= xferCmd_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_CH; i++) begin
                stage_r[i] <= REG_RST;
            end
        end else if (wordEvt) begin
            if (mode == MODE_BCAST) begin
                if (xferCmd_r[CMD_PICK_HI]) begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        stage_r[i] <= newWord;
                    end
                end
            end else if (extOk) begin
                stage_r[pick] <= newWord;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_CH; i++) begin
                outp_r[i] <= REG_RST;
            end
        end else if (wordEvt) begin
            unique case (mode)
                MODE_STAGE: begin
                end
                MODE_LOAD: begin
                    if (extOk) begin
                        outp_r[pick] <= newWord;
                    end
                end
                // all outputs, picked takes new data
                MODE_ALL: begin
                    if (extOk) begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            outp_r[i] <= (i == int'(pick)) ? newWord : stage_r[i];
                        end
                    end
                end
                MODE_BCAST: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        outp_r[i] <= xferCmd_r[CMD_PICK_HI] ? newWord : stage_r[i];
                    end
                end
            endcase
        end else if (loadEvt) begin
            for (int i = 0; i < NUM_CH; i++) begin
                outp_r[i] <= stage_r[i];
            end
        end
    end

    assign output_channel_a  = outp_r[0];
    assign output_channel_b  = outp_r[1];
    assign output_channel_c  = outp_r[2];
    assign output_channel_d  = outp_r[3];
    assign staging_channel_a = stage_r[0];
    assign staging_channel_b = stage_r[1];
    assign staging_channel_c = stage_r[2];
    assign staging_channel_d = stage_r[3];
    assign command_byte      = cmd_r;

    // ==================================================
    // assertions
    property p_stage_only;
        @(posedge clk) disable iff (reset)
        wordEvt && mode == MODE_STAGE && !loadEvt |=> $stable(outp_r[0]) && $stable(outp_r[3]);
    endproperty
    a_stage_only: assert property (p_stage_only) else $error("mode 00 changed an output");

    property p_load_one;
        @(posedge clk) disable iff (reset)
        wordEvt && mode == MODE_LOAD && extOk && pick == 2'h1 |=> outp_r[1] == $past(newWord);
    endproperty
    a_load_one: assert property (p_load_one) else $error("mode 01 did not load output");

    property p_load_all;
        @(posedge clk) disable iff (reset)
        wordEvt && mode == MODE_ALL && extOk && pick == 2'h0 |=> outp_r[2] == $past(stage_r[2]);
    endproperty
    a_load_all: assert property (p_load_all) else $error("mode 10 missed another channel");

    property p_pd_word;
        @(posedge clk) disable iff (reset)
        wordEvt && pdFlag && mode == MODE_BCAST && xferCmd_r[CMD_PICK_HI] |=>
            outp_r[2][DATA_W-1:0] == DATA_ZERO && outp_r[2][REG_W-1:DATA_W] == $past(xferHigh_r[7:6]);
    endproperty
    a_pd_word: assert property (p_pd_word) else $error("power-down word wrong");

    property p_bcast_stage;
        @(posedge clk) disable iff (reset)
        wordEvt && mode == MODE_BCAST && !xferCmd_r[CMD_PICK_HI] |=> outp_r[3] == $past(stage_r[3]);
    endproperty
    a_bcast_stage: assert property (p_bcast_stage) else $error("broadcast stored update wrong");

    property p_bcast_data;
        @(posedge clk) disable iff (reset)
        wordEvt && mode == MODE_BCAST && xferCmd_r[CMD_PICK_HI] |=> outp_r[0] == stage_r[0] && outp_r[0] == $past(newWord);
    endproperty
    a_bcast_data: assert property (p_bcast_data) else $error("broadcast data update wrong");

    property p_data_bits;
        @(posedge clk) disable iff (reset)
        wordEvt && !pdFlag && mode == MODE_STAGE && extOk && pick == 2'h0 |=>
            stage_r[0] == {2'b00, $past(xferHigh_r), $past(xferLow_r[7:4])};
    endproperty
    a_data_bits: assert property (p_data_bits) else $error("data word assembly wrong");

    property p_async_load_pin;
        @(posedge clk) disable iff (reset)
        loadEvt && !wordEvt |=> outp_r[1] == $past(stage_r[1]);
    endproperty
    a_async_load_pin: assert property (p_async_load_pin) else $error("load pin did not copy staging");

    property p_ext_block;
        @(posedge clk) disable iff (reset)
        wordEvt && mode != MODE_BCAST && !extOk |=> $stable(stage_r[0]) && $stable(stage_r[2]);
    endproperty
    a_ext_block: assert property (p_ext_block) else $error("update with wrong extended address");

    property p_cmd_hold;
        @(posedge clk) disable iff (reset)
        wordEvt |=> cmd_r == $past(xferCmd_r) ##1 (wordEvt || $stable(cmd_r));
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command register not held");

    c_load_one:  cover property (@(posedge clk) disable iff (reset) wordEvt && mode == MODE_LOAD && extOk);
    c_bcast:     cover property (@(posedge clk) disable iff (reset) wordEvt && mode == MODE_BCAST);
    c_async_load_pin:      cover property (@(posedge clk) disable iff (reset) loadEvt);
    c_powerdown: cover property (@(posedge clk) disable iff (reset) wordEvt && pdFlag);
endmodule

// File: testbench/qdu_master.sv
`timescale 1ns/1ps
// two-wire bus master model; its clock runs only inside frames
module qdu_master (
    output logic      sclClk,
    output logic      frameStart,
    output logic      sdaDrv,
    input  wire logic sdaLine
);
    // bus idle: clock low, data released to the pull-up
    initial begin
        sclClk = 1'b0;
        frameStart = 1'b0;
        sdaDrv = 1'b1;
    end

    // one link clock period
    task automatic tick();
        #3 sclClk = 1'b1;
        #3 sclClk = 1'b0;
    endtask

    // sends n bytes, returns which of them were acknowledged
    task automatic frame(input logic [7:0] b [8], input int n, output logic [7:0] ack);
        ack = 8'h00;
        frameStart = 1'b1;
        tick();
        frameStart = 1'b0;
        for (int i = 0; i < n; i++) begin
            for (int k = 7; k >= 0; k--) begin
                sdaDrv = b[i][k];
                tick();
            end
            sdaDrv = 1'b1;
            #3 sclClk = 1'b1;
            ack[i] = (sdaLine === 1'b0);
            #3 sclClk = 1'b0;
            // word spacing so the core sync keeps up
            if (i >= 3 && i[0]) #1200;
        end
    endtask
endmodule

// File: testbench/quad_dac_command_update_logic_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module quad_dac_command_update_logic_bench import qdu_pkg::*;;
    localparam logic [7:0] ADR = {ADDR_FIXED, 2'b01, 1'b0};
    logic             clk, reset, loadPin, sclClk, frameStart, sdaDrv, sdaIn, sdaOut, sdaOeN;
    logic [7:0]       command_byte;
    logic [REG_W-1:0] st [NUM_CH];
    logic [REG_W-1:0] ou [NUM_CH];
    logic [REG_W-1:0] es [NUM_CH];
    logic [REG_W-1:0] eo [NUM_CH];
    int               err_total, tests_run;

    // =====================================================
    // design, master and wire
    // open-drain line with pull-up
    assign sdaIn = (sdaOeN === 1'b0 && sdaOut === 1'b0) ? 1'b0 : sdaDrv;
    qdu_master M (.sclClk(sclClk), .frameStart(frameStart), .sdaDrv(sdaDrv), .sdaLine(sdaIn));
    qdu_top DUT (.clk(clk), .reset(reset), .sclClk(sclClk), .frameStart(frameStart), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addr_pin_hi(1'b0), .addr_pin_lo(1'b1),
        .ext_addr_bit_hi(1'b1), .ext_addr_bit_lo(1'b0), .async_load_pin(loadPin),
        .output_channel_a(ou[0]), .output_channel_b(ou[1]), .output_channel_c(ou[2]),
        .output_channel_d(ou[3]), .staging_channel_a(st[0]), .staging_channel_b(st[1]),
        .staging_channel_c(st[2]), .staging_channel_d(st[3]), .command_byte(command_byte));

    // core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // =====================================================
    // expected register model and helpers
    task automatic upd(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l);
        logic [REG_W-1:0] v;
        int               ch;
        // power-down code or twelve data bits
        v = c[CMD_PD] ? {h[7:6], DATA_ZERO} : {2'b00, h, l[7:4]};
        ch = int'(c[2:1]);
        if (c[5:4] == MODE_BCAST) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (c[CMD_PICK_HI]) es[i] = v;
                eo[i] = es[i];
            end
        end else if (c[7:6] == 2'b10) begin
            es[ch] = v;
            if (c[5:4] == MODE_LOAD) eo[ch] = v;
            if (c[5:4] == MODE_ALL) eo = es;
        end
    endtask

    // compares all staging and output registers
    task automatic chk_all();
        for (int i = 0; i < NUM_CH; i++) begin
            `CHK("staging", es[i], st[i])
            `CHK("output", eo[i], ou[i])
        end
    endtask

    // one frame: address, command, high, low, then extra bytes
    task automatic wr(input logic [7:0] ad, input logic [7:0] c, input logic [7:0] h,
                      input logic [7:0] l, input int n, input logic [7:0] expAck, input bit take);
        logic [7:0] b [8];
        logic [7:0] ack;
        b = '{ad, c, h, l, h, l, 8'h00, 8'h00};
        M.frame(b, n, ack);
        `CHK("ack", expAck, ack)
        if (take) upd(c, h, l);
        repeat (12) @(posedge clk);
        #1;
        chk_all();
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under a millisecond
    initial begin
        #2000000;
        err_total++;
        end_of_test();
    end

    // =====================================================
    // test sequence
    initial begin
        reset = 1'b1;
        loadPin = 1'b0;
        err_total = 0;
        tests_run = 0;
        for (int i = 0; i < NUM_CH; i++) begin
            es[i] = REG_RST;
            eo[i] = REG_RST;
        end
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_all();
        `CHK("command", 8'h00, command_byte)
        // staging only, every channel
        for (int i = 0; i < NUM_CH; i++) begin
            wr(ADR, {5'h10, i[1:0], 1'b0}, {4'hA, 2'h0, i[1:0]}, 8'h5C, 4, 8'h0F, 1);
        end
        wr(ADR, 8'h9A, 8'h3C, 8'h7F, 4, 8'h0F, 1);
        `CHK("command", 8'h9A, command_byte)
        wr(ADR, 8'h52, 8'hFF, 8'hF0, 4, 8'h0F, 1);
        wr(8'h9C, 8'h9A, 8'hFF, 8'hF0, 4, 8'h00, 0);
        wr(8'h9B, 8'h9A, 8'hFF, 8'hF0, 4, 8'h00, 0);
        wr(ADR, 8'hA4, 8'h12, 8'h30, 4, 8'h0F, 1);
        wr(ADR, 8'h80, 8'h77, 8'h80, 4, 8'h0F, 1);
        // load pin after staging writes are done
        @(posedge clk);
        #1 loadPin = 1'b1;
        eo = es;
        repeat (10) @(posedge clk);
        #1 loadPin = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk_all();
        wr(ADR, 8'h97, 8'hC0, 8'h00, 6, 8'h0F, 1);
        wr(ADR, 8'hA1, 8'h40, 8'h00, 4, 8'h0F, 1);
        wr(ADR, 8'h82, 8'h5A, 8'hA0, 4, 8'h0F, 1);
        wr(ADR, 8'h90, 8'h9C, 8'h30, 6, 8'h3F, 1);
        wr(ADDR_BCAST, 8'h30, 8'h11, 8'h10, 4, 8'h0F, 1);
        wr(ADR, 8'h3E, 8'hDE, 8'hAD, 4, 8'h0F, 1);
        wr(ADR, 8'h35, 8'h80, 8'h00, 4, 8'h0F, 1);
        end_of_test();
    end
endmodule
